// File: bench/ocs_far_model.sv
// Far side: sampling clock, sample source and reference clock.
// Assumes the bench enables the reference only for secondary tests.
`timescale 1ns/1ps
`default_nettype none
module ocs_far_model (
  input wire logic ref_en_i,
  output logic samp_clk_o,
  output ocs_pkg::ocs_sample_s i_sample_o,
  output ocs_pkg::ocs_sample_s q_sample_o,
  output logic ref_clk_o
);
  logic [11:0] cnt_q = 12'h0;
  initial begin
    samp_clk_o = 1'b0;
    i_sample_o = 13'h0;
    q_sample_o = 13'h0;
    ref_clk_o = 1'b0;
  end
  // Sampling clock runs free at eight mclk periods, its edges on mclk falling edges
  always #160 samp_clk_o = ~samp_clk_o;
  // Counting words make a lost or doubled sample visible
  always @(posedge samp_clk_o) begin
    cnt_q <= cnt_q + 12'h1;
    i_sample_o <= {1'b0, cnt_q};
    q_sample_o <= {cnt_q[0], ~cnt_q};
    ref_clk_o <= ref_en_i & cnt_q[1];
  end
endmodule
`default_nettype wire

// File: bench/ocs_props.sv
// Port checker for the output clock sync block.
// Assumes ce_i is held high while it watches.
`timescale 1ns/1ps
`default_nettype none
module ocs_props (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic out_clock_reset_in_i,
  input wire logic extended_control_mode_i,
  input wire logic q_powerdown_in_i,
  input wire logic i_delayed_bus_oe_n_o,
  input wire ocs_pkg::ocs_sample_s q_main_bus_o,
  input wire logic i_out_clock_o,
  input wire logic q_out_clock_o,
  input wire logic sync_ref_out_a_o,
  input wire logic sync_ref_out_b_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Six cycles covers input sync plus the glitch window
  sequence s_rst_held;
    (out_clock_reset_in_i && extended_control_mode_i && !i_delayed_bus_oe_n_o) [*6];
  endsequence
  sequence s_q_down;
    q_powerdown_in_i [*6];
  endsequence
  // Power-down pin reaches the Q clock gate through the synchroniser
  sequence s_q_up;
    !q_powerdown_in_i [*3];
  endsequence
  chk_clk_in_phase: assert property (q_out_clock_o |-> i_out_clock_o)
    else $error("q clock high alone");
  chk_clk_match: assert property (s_q_up |-> q_out_clock_o == i_out_clock_o)
    else $error("q clock differs from i clock");
  chk_ref_copies: assert property (sync_ref_out_a_o == sync_ref_out_b_o)
    else $error("reference copies differ");
  chk_q_idle: assert property (s_q_down |-> !q_out_clock_o && q_main_bus_o == 13'h0)
    else $error("q side active in power down");
  chk_demux_held: assert property (s_rst_held |-> i_out_clock_o)
    else $error("output clock not held high");
  chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  chk_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answer pending");
  chk_r_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped");
  chk_b_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped");
endmodule
bind ocs_output_clock_sync ocs_props u_props (
  .mclk_i, .reset_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .s_axi_rdata_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o,
  .out_clock_reset_in_i, .extended_control_mode_i, .q_powerdown_in_i,
  .i_delayed_bus_oe_n_o, .q_main_bus_o, .i_out_clock_o, .q_out_clock_o,
  .sync_ref_out_a_o, .sync_ref_out_b_o
);
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the output clock sync block.
// Assumes the far-side model supplies sampling and reference clocks.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [1:0] RESP_OK = ocs_pkg::AXI_OKAY;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic aw_valid = 1'b0;
  logic w_valid = 1'b0;
  logic b_ready = 1'b0;
  logic ar_valid = 1'b0;
  logic r_ready = 1'b0;
  logic crst = 1'b0;
  logic qpd = 1'b0;
  logic extended_control_mode = 1'b0;
  logic ref_en = 1'b0;
  logic [5:0] aw_addr = 6'h0;
  logic [5:0] ar_addr = 6'h0;
  logic [31:0] w_data = 32'h0;
  logic aw_rdy, w_rdy, b_valid, ar_rdy, r_valid, i_oe_n, q_oe_n, i_clk, q_clk, samp, ref_clk, ref_a;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_data, rd;
  ocs_pkg::ocs_sample_s i_smp, q_smp, i_main, i_dly, q_main, q_dly;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  always #20 mclk = ~mclk;
  ocs_far_model far (.ref_en_i(ref_en), .samp_clk_o(samp), .i_sample_o(i_smp),
    .q_sample_o(q_smp), .ref_clk_o(ref_clk));
  ocs_output_clock_sync uut (
    .mclk_i(mclk), .reset_i(reset), .ce_i(1'b1),
    .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_rdy),
    .s_axi_wdata_i(w_data), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_valid),
    .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid),
    .s_axi_bready_i(b_ready), .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid),
    .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
    .s_axi_rvalid_o(r_valid), .s_axi_rready_i(r_ready), .samp_clk_i(samp),
    .i_sample_i(i_smp), .q_sample_i(q_smp), .out_clock_reset_in_i(crst),
    .q_powerdown_in_i(qpd), .extended_control_mode_i(extended_control_mode), .ref_clk_i(ref_clk),
    .i_main_bus_o(i_main), .i_delayed_bus_o(i_dly), .i_delayed_bus_oe_n_o(i_oe_n),
    .q_main_bus_o(q_main), .q_delayed_bus_o(q_dly), .q_delayed_bus_oe_n_o(q_oe_n),
    .i_out_clock_o(i_clk), .q_out_clock_o(q_clk), .sync_ref_out_a_o(ref_a), .sync_ref_out_b_o());
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Ready raised late so the answer must stand a cycle
  task automatic axw(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    forever begin
      @(posedge mclk);
      if (b_valid && b_ready) break;
      if (aw_rdy) aw_valid <= 1'b0;
      if (w_rdy) w_valid <= 1'b0;
      if (b_valid) b_ready <= 1'b1;
    end
    b_ready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, b_resp});
  endtask
  task automatic axr(input logic [5:0] a, input logic [1:0] er);
    ar_addr <= a;
    ar_valid <= 1'b1;
    forever begin
      @(posedge mclk);
      if (r_valid && r_ready) break;
      if (ar_rdy) ar_valid <= 1'b0;
      if (r_valid) r_ready <= 1'b1;
    end
    r_ready <= 1'b0;
    rd = r_data;
    chk("rresp", {30'h0, er}, {30'h0, r_resp});
  endtask
  task automatic wchg();
    ocs_pkg::ocs_sample_s v;
    v = i_main;
    for (int k = 0; k < 40 && i_main === v; k++) @(posedge mclk);
  endtask
  task automatic rel();
    @(negedge samp);
    @(posedge mclk);
    crst <= 1'b0;
  endtask
  // Counts sampling edges from release until the held clock drops; the first is the reference edge
  task automatic align(input int e, input logic redo);
    int n;
    logic sp;
    n = 0;
    crst <= 1'b1;
    repeat (20) @(posedge mclk);
    chk("held", 32'h1, {31'h0, i_clk});
    if (redo) begin
      rel();
      repeat (2) @(posedge samp);
      @(posedge mclk);
      crst <= 1'b1;
      repeat (20) @(posedge mclk);
    end
    rel();
    sp = samp;
    for (int k = 0; k < 200; k++) begin
      @(posedge mclk);
      if (i_clk !== 1'b1) break;
      if (samp && !sp) n++;
      sp = samp;
    end
    if (e != 0) chk("sync_edges", e, n - 1);
    $display("test align done");
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    axr(6'h00, RESP_OK);
    chk("ctrl", 32'h1, rd);
    axr(6'h38, RESP_OK);
    chk("phase", 32'h8, rd);
    axr(6'h04, RESP_OK);
    chk("tad", 32'h0, rd);
    axw(6'h10, 32'h1, ocs_pkg::AXI_SLVERR);
    axr(6'h10, ocs_pkg::AXI_SLVERR);
    chk("unmapped", 32'h0, rd);
    $display("test regs done");
  endtask
  task automatic t_qpd();
    qpd <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("q_clk", 32'h0, {31'h0, q_clk});
    chk("q_main", 32'h0, {19'h0, q_main});
    chk("q_oe_n", 32'h1, {31'h0, q_oe_n});
    qpd <= 1'b0;
    repeat (10) @(posedge mclk);
    $display("test qpd done");
  endtask
  task automatic t_bus(input logic dmx);
    ocs_pkg::ocs_sample_s v;
    axw(6'h00, {31'h0, dmx}, RESP_OK);
    repeat (20) @(posedge mclk);
    chk("i_oe_n", {31'h0, !dmx}, {31'h0, i_oe_n});
    chk("q_oe_n", {31'h0, !dmx}, {31'h0, q_oe_n});
    wchg();
    v = i_main;
    if (dmx) chk("pair", {20'h0, v.data + 12'h1}, {20'h0, i_dly.data});
    if (dmx) chk("q_pair", {20'h0, ~(v.data + 12'h1)}, {20'h0, q_dly.data});
    wchg();
    chk("step", {20'h0, v.data + (dmx ? 12'h2 : 12'h1)}, {20'h0, i_main.data});
    $display("test bus done");
  endtask
  task automatic t_noecm();
    axw(6'h00, 32'h3, RESP_OK);
    crst <= 1'b1;
    repeat (20) @(posedge mclk);
    axr(6'h08, RESP_OK);
    chk("hold", 32'h0, {31'h0, rd[ocs_pkg::STAT_HOLD]});
    crst <= 1'b0;
    $display("test noecm done");
  endtask
  task automatic t_sync();
    extended_control_mode <= 1'b1;
    axw(6'h00, 32'h3, RESP_OK);
    align(0, 1'b0);
    align(4, 1'b0);
    align(4, 1'b0);
    align(4, 1'b1);
    axw(6'h38, 32'h0, RESP_OK);
    align(5, 1'b0);
    $display("test sync done");
  endtask
  task automatic t_sec();
    axw(6'h00, 32'hd, RESP_OK);
    ref_en <= 1'b1;
    repeat (2) @(posedge ref_clk);
    repeat (7) @(posedge mclk);
    chk("sec_hi", 32'h1, {31'h0, i_clk});
    chk("ref_hi", 32'h1, {31'h0, ref_a});
    repeat (17) @(posedge mclk);
    chk("sec_lo", 32'h0, {31'h0, i_clk});
    chk("ref_lo", 32'h0, {31'h0, ref_a});
    ref_en <= 1'b0;
    $display("test sec done");
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_qpd();
    t_bus(1'b1);
    t_bus(1'b0);
    t_noecm();
    t_sync();
    t_sec();
    stop_test();
  end
endmodule
`default_nettype wire

// File: core/ocs_output_clock_sync.sv
// Output clock generation, data alignment and multi-device sync control.
// Assumes sampling clock, reset pulse and reference clock arrive unsynchronised.
// Contract
// [R1] Sample words leave at the same aggregate rate they are sampled.
// [R2] Receiver may capture one demux bus only, halving the data rate.
// [R3] Non-demux: data on main buses only, delayed buses not driven.
// [R4] Q powered down: Q bus, Q clock and Q over-range are idle.
// [R5] Clock reset works only in extended control mode, disabled after reset.
// [R6] I and Q output clocks identical and in phase while Q is powered up; Q clock held low in power down.
// [R7] Reset pulse has a minimum width and timed release by the far end.
// [R8] Reset pulse may assert asynchronously; the device accepts it.
// [R9] While reset held: demux holds clock high, non-demux keeps toggling.
// [R10] A narrow clock glitch may precede the held state.
// [R11] 90 degree option: sync edge 4 edges after first edge after release.
// [R12] 0 degree option: sync edge 5 edges after first edge after release.
// [R13] Output clock resumes after a fixed output delay.
// [R14] First pulse after power-on leaves phase undefined; later ones repeatable.
// [R15] Controller issues one throwaway pulse before the aligning pulse.
// [R16] Software programs identical phase-select bits in every primary device.
// [R17] Secondary continuously aligns to primary, recovering next clock cycle.
// [R18] Demux clock has four phases; secondary picks phase from reference.
// [R19] Primary/secondary sync is enabled only through control registers.
// [R20] Output clock derives from sampling clock, shifted by aperture adjust.
// [R21] Reassertion before sync edge abandons alignment and restarts the count.
`timescale 1ns/1ps
`default_nettype none
module ocs_output_clock_sync (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // AXI4-Lite slave
  input wire logic [ocs_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ocs_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Converter side
  input wire logic samp_clk_i,
  input wire ocs_pkg::ocs_sample_s i_sample_i,
  input wire ocs_pkg::ocs_sample_s q_sample_i,
  input wire logic out_clock_reset_in_i,
  input wire logic q_powerdown_in_i,
  input wire logic extended_control_mode_i,
  input wire logic ref_clk_i,
  // Output side
  output ocs_pkg::ocs_sample_s i_main_bus_o,
  output ocs_pkg::ocs_sample_s i_delayed_bus_o,
  output logic i_delayed_bus_oe_n_o,
  output ocs_pkg::ocs_sample_s q_main_bus_o,
  output ocs_pkg::ocs_sample_s q_delayed_bus_o,
  output logic q_delayed_bus_oe_n_o,
  output logic i_out_clock_o,
  output logic q_out_clock_o,
  output logic sync_ref_out_a_o,
  output logic sync_ref_out_b_o
);
  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  localparam int NSYNC = 5 + 2 * $bits(ocs_pkg::ocs_sample_s);
  logic [NSYNC-1:0] pin_meta_q;
  logic [NSYNC-1:0] pin_sync_q;
  wire [NSYNC-1:0] pin_raw = {samp_clk_i, out_clock_reset_in_i, q_powerdown_in_i,
                              extended_control_mode_i, ref_clk_i, i_sample_i, q_sample_i};
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else if (ce_i) begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end
  wire samp_s = pin_sync_q[NSYNC-1];
  wire rst_s = pin_sync_q[NSYNC-2];
  wire qpd_s = pin_sync_q[NSYNC-3];
  wire ecm_s = pin_sync_q[NSYNC-4];
  wire ref_s = pin_sync_q[NSYNC-5];
  ocs_pkg::ocs_sample_s i_smp_s;
  ocs_pkg::ocs_sample_s q_smp_s;
  assign {i_smp_s, q_smp_s} = pin_sync_q[NSYNC-6:0];
  // Edge detection on the synchronised copies only
  logic samp_d1_q;
  logic ref_d1_q;
  logic qpd_d1_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      samp_d1_q <= 1'b0;
      ref_d1_q <= 1'b0;
      qpd_d1_q <= 1'b0;
    end else if (ce_i) begin
      samp_d1_q <= samp_s;
      ref_d1_q <= ref_s;
      qpd_d1_q <= qpd_s;
    end
  end
  wire se = samp_s & ~samp_d1_q;
  wire ref_rise = ref_s & ~ref_d1_q;
  wire qpd_fall = qpd_d1_q & ~qpd_s;
  // Data bits may resolve a cycle after the strobe, so capture waits one cycle
  logic se_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      se_q <= 1'b0;
    end else if (ce_i) begin
      se_q <= se;
    end
  end
  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [3:0] ctrl_q;
  logic [1:0] tad_q;
  logic [1:0] phsel_q;
  wire demux = ctrl_q[ocs_pkg::CTRL_DEMUX];
  wire rst_act = rst_s & ecm_s & ctrl_q[ocs_pkg::CTRL_RST_EN]; // [R5] [R8]
  wire secondary = ctrl_q[ocs_pkg::CTRL_PSS] & ctrl_q[ocs_pkg::CTRL_SECONDARY]; // [R19]
  wire sel_90 = phsel_q[0];
  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  logic aw_have_q;
  logic w_have_q;
  logic [3:0] aw_idx_q;
  logic aw_err_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  assign s_axi_awready_o = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready_o = ~w_have_q & ~bvalid_q;
  assign s_axi_arready_o = ~rvalid_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
  wire w_take = s_axi_wvalid_i & s_axi_wready_o;
  wire ar_take = s_axi_arvalid_i & s_axi_arready_o;
  wire wr_go = aw_have_q & w_have_q;
  wire [3:0] aw_idx = s_axi_awaddr_i[ocs_pkg::ADDR_W-1:2];
  wire [3:0] ar_idx = s_axi_araddr_i[ocs_pkg::ADDR_W-1:2];
  wire aw_ok = (aw_idx == ocs_pkg::IDX_CTRL) | (aw_idx == ocs_pkg::IDX_TAD) |
               (aw_idx == ocs_pkg::IDX_PHASE);
  wire wr_ctrl = wr_go & ~aw_err_q & (aw_idx_q == ocs_pkg::IDX_CTRL) & wstrb_q[0];
  wire wr_tad = wr_go & ~aw_err_q & (aw_idx_q == ocs_pkg::IDX_TAD) & wstrb_q[0];
  wire wr_phase = wr_go & ~aw_err_q & (aw_idx_q == ocs_pkg::IDX_PHASE) & wstrb_q[0];
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= '0;
      aw_err_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= ocs_pkg::AXI_OKAY;
    end else if (ce_i) begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= aw_idx;
        aw_err_q <= ~aw_ok;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= aw_err_q ? ocs_pkg::AXI_SLVERR : ocs_pkg::AXI_OKAY;
      end else if (bvalid_q & s_axi_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= ocs_pkg::CTRL_RESET; // [R5]
      tad_q <= ocs_pkg::TAD_RESET;
      phsel_q <= ocs_pkg::PHASE_RESET;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_q[3:0]; // [R19]
      end
      if (wr_tad) begin
        tad_q <= wdata_q[1:0];
      end
      if (wr_phase) begin
        phsel_q <= wdata_q[ocs_pkg::PHASE_MSB:ocs_pkg::PHASE_LSB];
      end
    end
  end
  // --------------------------------------------------------------------------
  // Clock reset sequencing
  // --------------------------------------------------------------------------
  ocs_pkg::ocs_state_e state_q;
  logic [2:0] cnt_q;
  logic [1:0] phase_q;
  logic primed_q;
  wire [2:0] sync_dly = sel_90 ? ocs_pkg::SYNC_DLY_90 : ocs_pkg::SYNC_DLY_0; // [R11] [R12]
  wire sync_edge = (state_q == ocs_pkg::ST_WAIT) & se & (cnt_q == sync_dly);
  wire held = demux & (state_q != ocs_pkg::ST_RUN); // [R9]
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ocs_pkg::ST_RUN;
      cnt_q <= '0;
    end else if (ce_i) begin
      unique case (state_q)
        ocs_pkg::ST_RUN: begin
          if (rst_act) begin
            state_q <= ocs_pkg::ST_HOLD; // [R8]
          end
        end
        ocs_pkg::ST_HOLD: begin
          if (!rst_act && se) begin
            state_q <= ocs_pkg::ST_WAIT;
            cnt_q <= 3'h1;
          end
        end
        ocs_pkg::ST_WAIT: begin
          if (rst_act) begin
            state_q <= ocs_pkg::ST_HOLD; // [R21]
          end else if (sync_edge) begin
            state_q <= ocs_pkg::ST_RUN;
          end else if (se) begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
        default: begin
          state_q <= ocs_pkg::ST_RUN;
        end
      endcase
    end
  end
  // Phase counter: four phases of the sampling clock in demux
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_q <= '0;
      primed_q <= 1'b0;
    end else if (ce_i) begin
      if (sync_edge) begin
        primed_q <= 1'b1;
      end else if (qpd_fall) begin
        primed_q <= 1'b0; // [R14]
      end
      if (sync_edge && primed_q) begin
        phase_q <= '0; // [R14]
      end else if (secondary && ref_rise) begin
        phase_q <= ocs_pkg::REF_ALIGN_PHASE; // [R17] [R18]
      end else if (se) begin
        phase_q <= phase_q + 2'h1;
      end
    end
  end
  // First pulse leaves the phase free-running, so alignment needs a second one
  wire [1:0] shifted = phase_q + tad_q; // [R20]
  wire clk_raw = demux ? shifted[1] : shifted[0]; // [R18]
  wire clk_d = held | clk_raw; // [R9] [R10]
  // --------------------------------------------------------------------------
  // Data capture
  // --------------------------------------------------------------------------
  ocs_pkg::ocs_sample_s i_pend_q;
  ocs_pkg::ocs_sample_s q_pend_q;
  ocs_pkg::ocs_sample_s i_main_q;
  ocs_pkg::ocs_sample_s i_del_q;
  ocs_pkg::ocs_sample_s q_main_q;
  ocs_pkg::ocs_sample_s q_del_q;
  logic out_clk_q;
  logic del_oe_n_q;
  // Phase has already stepped when the delayed capture lands, so parity flips
  wire slot_even = phase_q[0];
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      i_pend_q <= '0;
      q_pend_q <= '0;
      i_main_q <= '0;
      i_del_q <= '0;
      q_main_q <= '0;
      q_del_q <= '0;
    end else if (ce_i && se_q) begin
      if (!demux) begin
        i_main_q <= i_smp_s; // [R1] [R3]
        q_main_q <= q_smp_s;
      end else if (slot_even) begin
        i_pend_q <= i_smp_s;
        q_pend_q <= q_smp_s;
      end else begin
        i_main_q <= i_pend_q; // [R1] [R2]
        q_main_q <= q_pend_q;
        i_del_q <= i_smp_s;
        q_del_q <= q_smp_s;
      end
    end
  end
  // Fixed one-cycle output stage gives a constant delay to the pins
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      out_clk_q <= 1'b0;
      del_oe_n_q <= 1'b0;
    end else if (ce_i) begin
      out_clk_q <= clk_d; // [R13]
      del_oe_n_q <= ~demux; // [R3]
    end
  end
  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign i_out_clock_o = out_clk_q; // [R6]
  assign q_out_clock_o = out_clk_q & ~qpd_s; // [R4] [R6]
  assign sync_ref_out_a_o = out_clk_q;
  assign sync_ref_out_b_o = out_clk_q;
  assign i_main_bus_o = i_main_q;
  assign i_delayed_bus_o = i_del_q;
  assign i_delayed_bus_oe_n_o = del_oe_n_q;
  assign q_main_bus_o = qpd_s ? '0 : q_main_q; // [R4]
  assign q_delayed_bus_o = qpd_s ? '0 : q_del_q;
  assign q_delayed_bus_oe_n_o = del_oe_n_q | qpd_s;
  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  wire [31:0] status_w = {27'h0, primed_q, state_q == ocs_pkg::ST_WAIT, state_q == ocs_pkg::ST_HOLD, phase_q};
  wire [31:0] rd_mux = (ar_idx == ocs_pkg::IDX_CTRL) ? {28'h0, ctrl_q} :
                       (ar_idx == ocs_pkg::IDX_TAD) ? {30'h0, tad_q} :
                       (ar_idx == ocs_pkg::IDX_STATUS) ? status_w :
                       (ar_idx == ocs_pkg::IDX_PHASE) ? {27'h0, phsel_q, 3'h0} : 32'h0;
  wire ar_ok = (ar_idx == ocs_pkg::IDX_CTRL) | (ar_idx == ocs_pkg::IDX_TAD) |
               (ar_idx == ocs_pkg::IDX_STATUS) | (ar_idx == ocs_pkg::IDX_PHASE);
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= ocs_pkg::AXI_OKAY;
    end else if (ce_i) begin
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= ar_ok ? ocs_pkg::AXI_OKAY : ocs_pkg::AXI_SLVERR;
      end else if (rvalid_q & s_axi_rready_i) begin
        rvalid_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: shared/ocs_pkg.sv
// Package for the output clock and sync control block.
// Assumes a 32-bit AXI4-Lite register bus and word-aligned registers.
package ocs_pkg;
  // --------------------------------------------------------------------------
  // Register map (index, byte address is four times the index)
  // --------------------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_TAD = 4'h1;
  localparam logic [3:0] IDX_STATUS = 4'h2;
  localparam logic [3:0] IDX_PHASE = 4'he;
  localparam int ADDR_W = 6;
  // CTRL fields
  localparam int CTRL_DEMUX = 0;
  localparam int CTRL_RST_EN = 1;
  localparam int CTRL_PSS = 2;
  localparam int CTRL_SECONDARY = 3;
  localparam logic [3:0] CTRL_RESET = 4'h1;
  // PHASE fields: bits 4:3, bit 3 high selects the 90 degree option
  localparam int PHASE_LSB = 3;
  localparam int PHASE_MSB = 4;
  localparam logic [1:0] PHASE_RESET = 2'h1;
  // TAD field: sampling-edge shift of the output clock
  localparam logic [1:0] TAD_RESET = 2'h0;
  // STATUS fields
  localparam int STAT_PHASE_LSB = 0;
  localparam int STAT_HOLD = 2;
  localparam int STAT_WAIT = 3;
  localparam int STAT_PRIMED = 4;
  // --------------------------------------------------------------------------
  // Timing counts in sampling-clock edges, AXI response codes and sample width
  // --------------------------------------------------------------------------
  localparam logic [2:0] SYNC_DLY_90 = 3'h4;
  localparam logic [2:0] SYNC_DLY_0 = 3'h5;
  localparam logic [1:0] REF_ALIGN_PHASE = 2'h2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam int SAMPLE_W = 12;
  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic ovr;
    logic [SAMPLE_W-1:0] data;
  } ocs_sample_s;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HOLD = 3'b010,
    ST_WAIT = 3'b100
  } ocs_state_e;
endpackage
